// [ifc_pkg.sv]
// Package for the interrupt flag and control register block.
// Assumes an APB3 master with 32-bit data and one aligned word per register.
package ifc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTL_ONE = 8'h00;
   localparam logic [7:0] OFF_CTL_TWO = 8'h04;
   localparam logic [7:0] OFF_FLAGS0 = 8'h08;
   localparam logic [7:0] OFF_FLAGS1 = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STS = 8'h10;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int B_ADDR_ERR = 3;
   localparam int B_STACK_ERR = 2;
   localparam int B_OSC_FAIL = 1;
   localparam int B_ALT_IVT = 15;
   localparam int B_TIMED_DIS = 14;
   localparam int N_EXT = 5;
   localparam int B_EXT0_W0 = 0;
   localparam int B_EXT1_W1 = 4;
   localparam int B_EXT2_W1 = 13;
   localparam int B_STS_F0 = 3;
   localparam int B_STS_F1 = 4;
   localparam int B_EP0 = 0;
   localparam int B_EP1 = 1;
   localparam int B_EP2 = 2;
   localparam int B_EP3 = 3;
   localparam int B_EP4 = 4;

   // ----------------------------------------------------------------
   // Request source positions in the flag words
   // ----------------------------------------------------------------
   localparam int B_DMA1_W0 = 14;
   localparam int B_CONV1_W0 = 13;
   localparam int B_SER1_TX_W0 = 12;
   localparam int B_SER1_RX_W0 = 11;
   localparam int B_SPI1_EV_W0 = 10;
   localparam int B_SPI1_FLT_W0 = 9;
   localparam int B_TMR3_W0 = 8;
   localparam int B_TMR2_W0 = 7;
   localparam int B_CMP2_W0 = 6;
   localparam int B_CAP2_W0 = 5;
   localparam int B_DMA0_W0 = 4;
   localparam int B_TMR1_W0 = 3;
   localparam int B_CMP1_W0 = 2;
   localparam int B_CAP1_W0 = 1;
   localparam int B_SER2_TX_W1 = 15;
   localparam int B_SER2_RX_W1 = 14;
   localparam int B_TMR5_W1 = 12;
   localparam int B_TMR4_W1 = 11;
   localparam int B_CMP4_W1 = 10;
   localparam int B_CMP3_W1 = 9;
   localparam int B_DMA2_W1 = 8;
   localparam int B_CAP8_W1 = 7;
   localparam int B_CAP7_W1 = 6;
   localparam int B_CONV2_W1 = 5;
   localparam int B_PIN_CHG_W1 = 3;
   localparam int B_I2C1_MST_W1 = 1;
   localparam int B_I2C1_SLV_W1 = 0;

   // ----------------------------------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CTL1_MASK = 16'h000e;
   localparam logic [15:0] CTL2_WMASK = 16'h801f;
   localparam logic [15:0] FLAGS0_MASK = 16'h7fff;
   localparam logic [15:0] FLAGS1_MASK = 16'hfffb;
   localparam logic [4:0] IRQ_MASK = 5'h1f;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [4:0] RST_IRQ = 5'h00;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic addr_err;
      logic stack_err;
      logic osc_fail;
   } ifc_trap_s;

   typedef struct packed {
      logic [15:0] w1;
      logic [15:0] w0;
   } ifc_src_s;

endpackage

// [ifc_regs.sv]
// Interrupt flag and control registers behind an APB3 slave.
// Assumes trap and peripheral request pulses on pclk; ext pins asynchronous.
//
// Function
// - Address error trap sets control-one bit 3
// - Stack error trap sets control-one bit 2
// - Oscillator failure trap sets control-one bit 1
// - Unimplemented bits always read as zero
// - Bit 15 selects alternate vector table
// - Bit 14 reads timed disable status
// - Polarity bit 1 negative edge, 0 positive
// - Flags set by requests, software read/write
// - Flag word0 low byte source layout
// - Flag word0 high byte source layout
// - Flag word1 high byte source layout
// - Flag word1 low byte source layout
// - Control two and flags clear at reset
`timescale 1ns/1ps
`default_nettype none

module ifc_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ifc_pkg::ifc_trap_s trap_evt,
   input wire ifc_pkg::ifc_src_s src_req,
   input wire logic timed_irq_disable_active,
   input wire logic [4:0] ext_irq_pin,
   output logic alt_vector_table_select,
   output ifc_pkg::ifc_src_s flags_out,
   output logic [4:0] ext_edge_pulse,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0] ctl1_q;
   logic [15:0] ctl2_q;
   logic [15:0] flags0_q;
   logic [15:0] flags1_q;
   logic [4:0] sts_q;
   logic [4:0] msk_q;
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic [4:0] prev_q;
   logic [4:0] edge_q;
   logic dis_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic [4:0] edge_d;
   logic wr;
   logic mapped;
   logic [15:0] set0;
   logic [15:0] set1;
   logic [15:0] trap_set;
   logic [4:0] sts_set;
   logic [31:0] rd_d;
   logic flag0_any;
   logic flag1_any;
   logic [4:0] pol_v;

   // Named views of the control fields
   logic address_error_trap_flag;
   logic stack_error_trap_flag;
   logic osc_failure_trap_flag;
   logic ext_irq0_edge_polarity;
   logic ext_irq1_edge_polarity;
   logic ext_irq2_edge_polarity;
   logic ext_irq3_edge_polarity;
   logic ext_irq4_edge_polarity;

   // Named request lines, one per flag
   logic dma_ch1_done_flag_req;
   logic conv1_done_flag_req;
   logic serial1_tx_flag_req;
   logic serial1_rx_flag_req;
   logic spi1_event_flag_req;
   logic spi1_fault_flag_req;
   logic timer3_flag_req;
   logic timer2_flag_req;
   logic compare2_flag_req;
   logic capture2_flag_req;
   logic dma_ch0_done_flag_req;
   logic timer1_flag_req;
   logic compare1_flag_req;
   logic capture1_flag_req;
   logic ext_irq0_flag_req;
   logic serial2_tx_flag_req;
   logic serial2_rx_flag_req;
   logic ext_irq2_flag_req;
   logic timer5_flag_req;
   logic timer4_flag_req;
   logic compare4_flag_req;
   logic compare3_flag_req;
   logic dma_ch2_done_flag_req;
   logic capture8_flag_req;
   logic capture7_flag_req;
   logic conv2_done_flag_req;
   logic ext_irq1_flag_req;
   logic pin_change_flag_req;
   logic i2c1_master_event_flag_req;
   logic i2c1_slave_event_flag_req;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Data is looked up in the setup cycle so prdata comes from a flop
   // and the access phase always completes with no wait state.
   assign wr = psel & penable & pready_q & pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_d = 32'h0000_0000;
      if (paddr == ifc_pkg::OFF_CTL_ONE) begin
         // Bit 0 and the upper bits stay zero
         rd_d[ifc_pkg::B_ADDR_ERR] = address_error_trap_flag;
         rd_d[ifc_pkg::B_STACK_ERR] = stack_error_trap_flag;
         rd_d[ifc_pkg::B_OSC_FAIL] = osc_failure_trap_flag;
      end else if (paddr == ifc_pkg::OFF_CTL_TWO) begin
         // Bits 13 to 5 stay zero
         rd_d[ifc_pkg::B_ALT_IVT] = ctl2_q[ifc_pkg::B_ALT_IVT];
         rd_d[ifc_pkg::N_EXT-1:0] = pol_v;
         rd_d[ifc_pkg::B_TIMED_DIS] = dis_q;
      end else if (paddr == ifc_pkg::OFF_FLAGS0) begin
         rd_d[15:0] = flags0_q & ifc_pkg::FLAGS0_MASK;
      end else if (paddr == ifc_pkg::OFF_FLAGS1) begin
         rd_d[15:0] = flags1_q & ifc_pkg::FLAGS1_MASK;
      end else if (paddr == ifc_pkg::OFF_IRQ_STS) begin
         rd_d[4:0] = sts_q;
      end else if (paddr == ifc_pkg::OFF_IRQ_MSK) begin
         rd_d[4:0] = msk_q;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         // Unmapped writes fall through the decode; only the error marks them
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // External inputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         prev_q <= 5'h00;
         edge_q <= 5'h00;
      end else begin
         // Two flops stand before any logic reads a pin
         sync1_q <= ext_irq_pin;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         edge_q <= edge_d;
      end
   end

   assign ext_irq0_edge_polarity = ctl2_q[ifc_pkg::B_EP0];
   assign ext_irq1_edge_polarity = ctl2_q[ifc_pkg::B_EP1];
   assign ext_irq2_edge_polarity = ctl2_q[ifc_pkg::B_EP2];
   assign ext_irq3_edge_polarity = ctl2_q[ifc_pkg::B_EP3];
   assign ext_irq4_edge_polarity = ctl2_q[ifc_pkg::B_EP4];
   // Polarity vector feeds the detector loop
   assign pol_v = {ext_irq4_edge_polarity, ext_irq3_edge_polarity, ext_irq2_edge_polarity,
                   ext_irq1_edge_polarity, ext_irq0_edge_polarity};

   genvar i;
   generate
      for (i = 0; i < ifc_pkg::N_EXT; i++) begin : g_ext
         // Only a pin change makes an edge; a polarity change alone sets no flag.
         assign edge_d[i] = pol_v[i] ? (prev_q[i] & ~sync2_q[i])
                                      : (~prev_q[i] & sync2_q[i]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control words
   // ----------------------------------------------------------------
   always_comb begin
      trap_set = 16'h0000;
      trap_set[ifc_pkg::B_ADDR_ERR] = trap_evt.addr_err;
      trap_set[ifc_pkg::B_STACK_ERR] = trap_evt.stack_err;
      trap_set[ifc_pkg::B_OSC_FAIL] = trap_evt.osc_fail;
   end

   // Trap flags as software sees them
   assign address_error_trap_flag = ctl1_q[ifc_pkg::B_ADDR_ERR];
   assign stack_error_trap_flag = ctl1_q[ifc_pkg::B_STACK_ERR];
   assign osc_failure_trap_flag = ctl1_q[ifc_pkg::B_OSC_FAIL];

   // Hardware set wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_q <= ifc_pkg::RST_WORD;
      end else if (wr && paddr == ifc_pkg::OFF_CTL_ONE) begin
         ctl1_q <= (pwdata[15:0] | trap_set) & ifc_pkg::CTL1_MASK;
      end else begin
         ctl1_q <= (ctl1_q | trap_set) & ifc_pkg::CTL1_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl2_q <= ifc_pkg::RST_WORD;
         dis_q <= 1'b0;
      end else begin
         dis_q <= timed_irq_disable_active;
         if (wr && paddr == ifc_pkg::OFF_CTL_TWO) begin
            ctl2_q <= pwdata[15:0] & ifc_pkg::CTL2_WMASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flag words
   // ----------------------------------------------------------------
   // Word0 requests; struct bit 0 is unused, that flag comes from the
   // edge detector.
   assign dma_ch1_done_flag_req = src_req.w0[ifc_pkg::B_DMA1_W0];
   assign conv1_done_flag_req = src_req.w0[ifc_pkg::B_CONV1_W0];
   assign serial1_tx_flag_req = src_req.w0[ifc_pkg::B_SER1_TX_W0];
   assign serial1_rx_flag_req = src_req.w0[ifc_pkg::B_SER1_RX_W0];
   assign spi1_event_flag_req = src_req.w0[ifc_pkg::B_SPI1_EV_W0];
   assign spi1_fault_flag_req = src_req.w0[ifc_pkg::B_SPI1_FLT_W0];
   assign timer3_flag_req = src_req.w0[ifc_pkg::B_TMR3_W0];
   assign timer2_flag_req = src_req.w0[ifc_pkg::B_TMR2_W0];
   assign compare2_flag_req = src_req.w0[ifc_pkg::B_CMP2_W0];
   assign capture2_flag_req = src_req.w0[ifc_pkg::B_CAP2_W0];
   assign dma_ch0_done_flag_req = src_req.w0[ifc_pkg::B_DMA0_W0];
   assign timer1_flag_req = src_req.w0[ifc_pkg::B_TMR1_W0];
   assign compare1_flag_req = src_req.w0[ifc_pkg::B_CMP1_W0];
   assign capture1_flag_req = src_req.w0[ifc_pkg::B_CAP1_W0];
   assign ext_irq0_flag_req = edge_q[0];

   // Word1 requests; struct bits 4 and 13 are unused.
   assign serial2_tx_flag_req = src_req.w1[ifc_pkg::B_SER2_TX_W1];
   assign serial2_rx_flag_req = src_req.w1[ifc_pkg::B_SER2_RX_W1];
   assign timer5_flag_req = src_req.w1[ifc_pkg::B_TMR5_W1];
   assign timer4_flag_req = src_req.w1[ifc_pkg::B_TMR4_W1];
   assign compare4_flag_req = src_req.w1[ifc_pkg::B_CMP4_W1];
   assign compare3_flag_req = src_req.w1[ifc_pkg::B_CMP3_W1];
   assign dma_ch2_done_flag_req = src_req.w1[ifc_pkg::B_DMA2_W1];
   assign capture8_flag_req = src_req.w1[ifc_pkg::B_CAP8_W1];
   assign capture7_flag_req = src_req.w1[ifc_pkg::B_CAP7_W1];
   assign conv2_done_flag_req = src_req.w1[ifc_pkg::B_CONV2_W1];
   assign pin_change_flag_req = src_req.w1[ifc_pkg::B_PIN_CHG_W1];
   assign i2c1_master_event_flag_req = src_req.w1[ifc_pkg::B_I2C1_MST_W1];
   assign i2c1_slave_event_flag_req = src_req.w1[ifc_pkg::B_I2C1_SLV_W1];
   assign ext_irq1_flag_req = edge_q[1];
   assign ext_irq2_flag_req = edge_q[2];

   always_comb begin
      set0 = 16'h0000;
      set0[ifc_pkg::B_DMA1_W0] = dma_ch1_done_flag_req;
      set0[ifc_pkg::B_CONV1_W0] = conv1_done_flag_req;
      set0[ifc_pkg::B_SER1_TX_W0] = serial1_tx_flag_req;
      set0[ifc_pkg::B_SER1_RX_W0] = serial1_rx_flag_req;
      set0[ifc_pkg::B_SPI1_EV_W0] = spi1_event_flag_req;
      set0[ifc_pkg::B_SPI1_FLT_W0] = spi1_fault_flag_req;
      set0[ifc_pkg::B_TMR3_W0] = timer3_flag_req;
      set0[ifc_pkg::B_TMR2_W0] = timer2_flag_req;
      set0[ifc_pkg::B_CMP2_W0] = compare2_flag_req;
      set0[ifc_pkg::B_CAP2_W0] = capture2_flag_req;
      set0[ifc_pkg::B_DMA0_W0] = dma_ch0_done_flag_req;
      set0[ifc_pkg::B_TMR1_W0] = timer1_flag_req;
      set0[ifc_pkg::B_CMP1_W0] = compare1_flag_req;
      set0[ifc_pkg::B_CAP1_W0] = capture1_flag_req;
      set0[ifc_pkg::B_EXT0_W0] = ext_irq0_flag_req;

      set1 = 16'h0000;
      set1[ifc_pkg::B_SER2_TX_W1] = serial2_tx_flag_req;
      set1[ifc_pkg::B_SER2_RX_W1] = serial2_rx_flag_req;
      set1[ifc_pkg::B_EXT2_W1] = ext_irq2_flag_req;
      set1[ifc_pkg::B_TMR5_W1] = timer5_flag_req;
      set1[ifc_pkg::B_TMR4_W1] = timer4_flag_req;
      set1[ifc_pkg::B_CMP4_W1] = compare4_flag_req;
      set1[ifc_pkg::B_CMP3_W1] = compare3_flag_req;
      set1[ifc_pkg::B_DMA2_W1] = dma_ch2_done_flag_req;
      set1[ifc_pkg::B_CAP8_W1] = capture8_flag_req;
      set1[ifc_pkg::B_CAP7_W1] = capture7_flag_req;
      set1[ifc_pkg::B_CONV2_W1] = conv2_done_flag_req;
      set1[ifc_pkg::B_EXT1_W1] = ext_irq1_flag_req;
      set1[ifc_pkg::B_PIN_CHG_W1] = pin_change_flag_req;
      set1[ifc_pkg::B_I2C1_MST_W1] = i2c1_master_event_flag_req;
      set1[ifc_pkg::B_I2C1_SLV_W1] = i2c1_slave_event_flag_req;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags0_q <= ifc_pkg::RST_WORD;
      end else if (wr && paddr == ifc_pkg::OFF_FLAGS0) begin
         flags0_q <= (pwdata[15:0] | set0) & ifc_pkg::FLAGS0_MASK;
      end else begin
         flags0_q <= flags0_q | set0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags1_q <= ifc_pkg::RST_WORD;
      end else if (wr && paddr == ifc_pkg::OFF_FLAGS1) begin
         flags1_q <= (pwdata[15:0] | set1) & ifc_pkg::FLAGS1_MASK;
      end else begin
         flags1_q <= flags1_q | set1;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   assign flag0_any = |set0;
   assign flag1_any = |set1;

   // Trap bits first, then one summary bit per flag word
   always_comb begin
      sts_set = 5'h00;
      sts_set[2:0] = {trap_evt.addr_err, trap_evt.stack_err, trap_evt.osc_fail};
      sts_set[ifc_pkg::B_STS_F0] = flag0_any;
      sts_set[ifc_pkg::B_STS_F1] = flag1_any;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= ifc_pkg::RST_IRQ;
         msk_q <= ifc_pkg::RST_IRQ;
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & msk_q);
         if (wr && paddr == ifc_pkg::OFF_IRQ_STS) begin
            sts_q <= (sts_q & ~pwdata[4:0]) | sts_set;
         end else begin
            sts_q <= sts_q | sts_set;
         end
         if (wr && paddr == ifc_pkg::OFF_IRQ_MSK) begin
            msk_q <= pwdata[4:0] & ifc_pkg::IRQ_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign alt_vector_table_select = ctl2_q[ifc_pkg::B_ALT_IVT];
   assign flags_out.w0 = flags0_q;
   assign flags_out.w1 = flags1_q;
   assign ext_edge_pulse = edge_q;
   assign irq = irq_q;

endmodule

`default_nettype wire

// [ifc_src_model.sv]
// Model of the core and the request sources beside the register block.
// Assumes the bench calls its tasks; drives only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ifc_src_model (
   input wire logic pclk,
   output ifc_pkg::ifc_trap_s trap_evt,
   output ifc_pkg::ifc_src_s src_req,
   output logic timed_irq_disable_active,
   output logic [4:0] ext_irq_pin
);
   initial begin
      trap_evt = '0;
      src_req = '0;
      timed_irq_disable_active = 1'b0;
      ext_irq_pin = 5'h00;
   end
   // Trap and request sources emit one-cycle pulses only
   task automatic pulse(input logic [2:0] t, input logic [31:0] r);
      @(posedge pclk);
      trap_evt <= t;
      src_req <= r;
      @(posedge pclk);
      trap_evt <= '0;
      src_req <= '0;
   endtask
   task automatic level(input logic d, input logic [4:0] p);
      @(posedge pclk);
      timed_irq_disable_active <= d;
      ext_irq_pin <= p;
   endtask
endmodule
`default_nettype wire

// [ifc_regs_sva.sv]
// Checker on the ports of the flag and control register block.
// Assumes it is bound to every instance of that block.
`timescale 1ns/1ps
`default_nettype none
module ifc_regs_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ifc_pkg::ifc_src_s src_req,
   input wire logic alt_vector_table_select,
   input wire ifc_pkg::ifc_src_s flags_out,
   input wire logic [4:0] ext_edge_pulse
);
   localparam logic [15:0] M0 = 16'h7ffe;
   localparam logic [15:0] M1 = 16'hdfeb;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wr_two_s;
      setup_s ##1 (pwrite && paddr == ifc_pkg::OFF_CTL_TWO && pready);
   endsequence
   a_access_once: assert property (setup_s |=> pready ##1 !pready)
      else $error("access not one cycle");
   a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
      else $error("unmapped access not refused");
   a_read_hi_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_alt_follows: assert property (wr_two_s |=> alt_vector_table_select == $past(pwdata[15]))
      else $error("vector select not written");
   a_flag_set0: assert property ((src_req.w0 & M0) != 16'h0 |=>
      (flags_out.w0 & $past(src_req.w0) & M0) == ($past(src_req.w0) & M0))
      else $error("word0 flag not set");
   a_flag_set1: assert property ((src_req.w1 & M1) != 16'h0 |=>
      (flags_out.w1 & $past(src_req.w1) & M1) == ($past(src_req.w1) & M1))
      else $error("word1 flag not set");
   a_ext_to_flag: assert property (ext_edge_pulse[1] |=> flags_out.w1[4])
      else $error("edge did not set flag");
   a_reset_clear: assert property ($rose(presetn) |-> flags_out == 32'h0)
      else $error("flags not clear after reset");
endmodule
bind ifc_regs ifc_regs_sva chk (.*);
`default_nettype wire

// [ifc_regs_tb.sv]
// Self-checking bench for the flag and control register block.
// Assumes the source model and the bound checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
   checked++; \
   if ((s) !== (e)) begin \
      miscompares++; \
      $display("BAD %s exp %h got %h", n, e, s); \
   end \
end
module ifc_regs_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, alt, irq, er, tdis;
   logic [4:0] pins, pulses;
   ifc_pkg::ifc_trap_s trap_evt;
   ifc_pkg::ifc_src_s src_req, flags_out;
   int miscompares = 0, checked = 0;
   ifc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trap_evt(trap_evt), .src_req(src_req),
      .timed_irq_disable_active(tdis), .ext_irq_pin(pins), .alt_vector_table_select(alt),
      .flags_out(flags_out), .ext_edge_pulse(pulses), .irq(irq));
   ifc_src_model src (.pclk(pclk), .trap_evt(trap_evt), .src_req(src_req),
      .timed_irq_disable_active(tdis), .ext_irq_pin(pins));
   always #20 pclk = ~pclk;
   // Request holds until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         `CHK("reset word", 32'h0, rv)
      end
      apb(1'b1, 8'h20, 32'hffffffff);
      `CHK("unmapped", 1'b1, er)
   endtask
   task automatic t_trap;
      apb(1'b1, ifc_pkg::OFF_IRQ_MSK, 32'h4);
      for (int j = 0; j < 3; j++) begin
         src.pulse(3'(1 << j), 32'h0);
         apb(1'b0, ifc_pkg::OFF_CTL_ONE, 32'h0);
         `CHK("trap flag", 32'(2 << j), rv)
         `CHK("irq masked", 1'(j == 2), irq)
         apb(1'b1, ifc_pkg::OFF_CTL_ONE, 32'h0);
      end
      apb(1'b1, ifc_pkg::OFF_IRQ_STS, 32'h1f);
      repeat (2) @(negedge pclk);
      `CHK("irq cleared", 1'b0, irq)
   endtask
   task automatic t_flags;
      src.pulse(3'h0, 32'hffffffff);
      apb(1'b0, ifc_pkg::OFF_FLAGS0, 32'h0);
      `CHK("word0 set", 32'h7ffe, rv)
      apb(1'b0, ifc_pkg::OFF_FLAGS1, 32'h0);
      `CHK("word1 set", 32'hdfeb, rv)
      `CHK("flags out", 32'hdfeb7ffe, flags_out)
      apb(1'b1, ifc_pkg::OFF_FLAGS0, 32'h0);
      apb(1'b0, ifc_pkg::OFF_FLAGS0, 32'h0);
      `CHK("word0 clear", 32'h0, rv)
      apb(1'b1, ifc_pkg::OFF_FLAGS1, 32'hffffffff);
      apb(1'b0, ifc_pkg::OFF_FLAGS1, 32'h0);
      `CHK("word1 write", 32'hfffb, rv)
   endtask
   task automatic t_ctl2;
      src.level(1'b1, 5'h00);
      apb(1'b1, ifc_pkg::OFF_CTL_TWO, 32'hffffffff);
      apb(1'b0, ifc_pkg::OFF_CTL_TWO, 32'h0);
      `CHK("ctl two", 32'hc01f, rv)
      `CHK("alt select", 1'b1, alt)
      src.level(1'b0, 5'h00);
      apb(1'b0, ifc_pkg::OFF_CTL_TWO, 32'h0);
      `CHK("disable off", 32'h801f, rv)
   endtask
   // Polarity writes raise no edge; flags left by earlier tests are cleared after settling
   task automatic t_ext;
      apb(1'b1, ifc_pkg::OFF_CTL_TWO, 32'h2);
      repeat (8) @(negedge pclk);
      `CHK("alt off", 1'b0, alt)
      apb(1'b1, ifc_pkg::OFF_FLAGS0, 32'h0);
      apb(1'b1, ifc_pkg::OFF_FLAGS1, 32'h0);
      src.level(1'b0, 5'h07);
      repeat (8) @(negedge pclk);
      apb(1'b0, ifc_pkg::OFF_FLAGS0, 32'h0);
      `CHK("rise positive", 32'h1, rv)
      apb(1'b0, ifc_pkg::OFF_FLAGS1, 32'h0);
      `CHK("rise negative", 32'h2000, rv)
      src.level(1'b0, 5'h00);
      repeat (8) @(negedge pclk);
      apb(1'b0, ifc_pkg::OFF_FLAGS1, 32'h0);
      `CHK("fall negative", 32'h2010, rv)
   endtask
   task automatic summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_trap();
      t_flags();
      t_ctl2();
      t_ext();
      summarize();
   end
   initial begin
      #400000;
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
